//--- bad_top.sv
// board address decoder: local i/o selects, rom pair selects, ram request
`timescale 1ns/100ps
`include "bad_regs.svh"

module bad_top
    import bad_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        rst,
    input  wire logic [19:0] addr,
    input  wire logic [2:0]  cpu_status,
    input  wire logic        ale,
    input  wire logic        dt_r,
    input  wire logic        io_read_cmd_n,
    input  wire logic        io_write_cmd_n,
    input  wire logic        cycle_done,
    input  wire logic [1:0]  chip_size,
    input  wire logic        rom_expanded,
    input  wire logic [1:0]  config_switch,
    output logic             io_cycle_flag,
    output logic             local_io_ack_n,
    output logic             cpu_ready,
    output logic             irq_ctrl_sel_n,
    output logic             parallel_port_sel_n,
    output logic             timer_sel_n,
    output logic             serial_sel_n,
    output logic             local_buffer_en_n,
    output logic             local_target_n,
    output logic             xfer_direction,
    output logic [1:0]       periph_func,
    output logic             periph_rd_n,
    output logic             periph_wr_n,
    output logic             rom_ack_n,
    output logic             local_ram_req_n,
    output logic             rom_pair0_sel_n,
    output logic             rom_pair1_sel_n,
    output logic             rom_pair2_sel_n,
    output logic             rom_pair3_sel_n,
    output logic [11:0]      rom_chip_addr,
    output logic [2:0]       arb_status,
    output logic             arb_req
);

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic io_local(input logic [19:0] a);
        io_local = (a[15:0] & `BAD_IO_MASK) == `BAD_IO_MATCH;
    endfunction

    // active-low one-of-four; both select groups share it
    function automatic logic [3:0] dec4_n(input logic [1:0] code, input logic en);
        dec4_n = `BAD_SEL_NONE;
        if (en) begin
            dec4_n[code] = 1'b0;
        end
    endfunction

    bad_state_type st;
    bad_state_type next_st;

    logic range_out_a;
    logic range_out_b;
    logic sel_out_low;
    logic sel_out_high;
    logic expanded;
    logic active;
    logic io_hit;
    logic mem_hit;
    logic rom_hit;
    logic ram_hit;

    // ------------------------------------------------------------
    // rom window lookup
    // ------------------------------------------------------------
    // jumpers alone are not enough: both switches must also be off
    assign expanded = rom_expanded && (config_switch == `BAD_SW_OFF);

    bad_win_decode u_win (
        .win_bits     (st.addr[`BAD_WIN_MSB:`BAD_WIN_LSB]),
        .chip_size    (chip_size),
        .expanded     (expanded),
        .range_out_a  (range_out_a),
        .range_out_b  (range_out_b),
        .sel_out_low  (sel_out_low),
        .sel_out_high (sel_out_high)
    );

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        next_st = st;

        unique case (st.phase)
            BAD_IDLE: next_st.phase = BAD_IDLE;
            BAD_ADDR: next_st.phase = ale ? BAD_ADDR : BAD_DATA;
            BAD_DATA: next_st.phase = cycle_done ? BAD_IDLE : BAD_DATA;
            default:  next_st.phase = BAD_IDLE;
        endcase
        if (ale) begin
            next_st.phase   = BAD_ADDR;
            next_st.io_flag = ~cpu_status[`BAD_IO_S2];
            next_st.addr    = addr;
        end

        active  = st.phase != BAD_IDLE;
        io_hit  = active && st.io_flag && io_local(st.addr);
        mem_hit = active && !st.io_flag && !range_out_a && !range_out_b;
        rom_hit = mem_hit && st.addr[`BAD_A19];
        ram_hit = mem_hit && !st.addr[`BAD_A19];

        // odd port addresses are not filtered; software keeps to even ones
        next_st.ack_n        = ~io_hit;
        next_st.ready        = io_hit;
        next_st.periph_sel_n = dec4_n(st.addr[`BAD_SEL_MSB:`BAD_SEL_LSB], io_hit);
        next_st.func         = io_hit ? st.addr[`BAD_FUNC_MSB:`BAD_FUNC_LSB] : 2'h0;
        next_st.prd_n        = ~(io_hit && !io_read_cmd_n);
        next_st.pwr_n        = ~(io_hit && !io_write_cmd_n);

        next_st.rom_ack_n = ~rom_hit;
        next_st.ram_req_n = ~ram_hit;
        // pair decoder waits for the strobe to fall so a new address cannot glitch a socket
        next_st.pair_sel_n = dec4_n({sel_out_high, sel_out_low},
                                    rom_hit && st.phase == BAD_DATA);
        next_st.chip_addr  = rom_hit ? st.addr[`BAD_CHIP_MSB:`BAD_CHIP_LSB] : 12'h000;

        next_st.buf_en_n = ~(io_hit || rom_hit);
        next_st.target_n = ~(io_hit || rom_hit || ram_hit);
        next_st.dir      = ~dt_r;

        // off-board cycles only: status is latched on the board clock in the same cycle as the bus request
        next_st.arb_req = st.phase == BAD_DATA && st.target_n
                          && !(io_hit || rom_hit || ram_hit)
                          && cpu_status != `BAD_STAT_PASSIVE;
        if (next_st.arb_req) begin
            next_st.arb_status = cpu_status;
        end
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            st              <= '0;
            st.phase        <= BAD_IDLE;
            st.ack_n        <= 1'b1;
            st.periph_sel_n <= `BAD_SEL_NONE;
            st.buf_en_n     <= 1'b1;
            st.target_n     <= 1'b1;
            st.prd_n        <= 1'b1;
            st.pwr_n        <= 1'b1;
            st.rom_ack_n    <= 1'b1;
            st.ram_req_n    <= 1'b1;
            st.pair_sel_n   <= `BAD_SEL_NONE;
            st.arb_status   <= `BAD_STAT_PASSIVE;
        end else begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign io_cycle_flag       = st.io_flag;
    assign local_io_ack_n      = st.ack_n;
    assign cpu_ready           = st.ready;
    assign irq_ctrl_sel_n      = st.periph_sel_n[`BAD_SEL_IRQ];
    assign parallel_port_sel_n = st.periph_sel_n[`BAD_SEL_PAR];
    assign timer_sel_n         = st.periph_sel_n[`BAD_SEL_TMR];
    assign serial_sel_n        = st.periph_sel_n[`BAD_SEL_SER];
    assign local_buffer_en_n   = st.buf_en_n;
    assign local_target_n      = st.target_n;
    assign xfer_direction      = st.dir;
    assign periph_func         = st.func;
    assign periph_rd_n         = st.prd_n;
    assign periph_wr_n         = st.pwr_n;
    assign rom_ack_n           = st.rom_ack_n;
    assign local_ram_req_n     = st.ram_req_n;
    assign rom_pair0_sel_n     = st.pair_sel_n[0];
    assign rom_pair1_sel_n     = st.pair_sel_n[1];
    assign rom_pair2_sel_n     = st.pair_sel_n[2];
    assign rom_pair3_sel_n     = st.pair_sel_n[3];
    assign rom_chip_addr       = st.chip_addr;
    assign arb_status          = st.arb_status;
    assign arb_req             = st.arb_req;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);

    logic io_hit_q;
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            io_hit_q <= 1'b0;
        end else begin
            io_hit_q <= io_hit;
        end
    end

    property p_flag_capture;
        ale |=> io_cycle_flag == !$past(cpu_status[`BAD_IO_S2]);
    endproperty
    a_flag_capture: assert property (p_flag_capture)
        else $error("io flag not taken from status at strobe");

    property p_ack_cause;
        (st.phase != BAD_IDLE && st.io_flag && io_local(st.addr)) |=> !local_io_ack_n;
    endproperty
    a_ack_cause: assert property (p_ack_cause)
        else $error("local io ack missing for local address");

    property p_ack_only_local;
        !local_io_ack_n |-> io_hit_q && $past(st.io_flag)
            && ($past(st.addr[15:0]) & `BAD_IO_MASK) == `BAD_IO_MATCH;
    endproperty
    a_ack_only_local: assert property (p_ack_only_local)
        else $error("local io ack without local address");

    property p_ack_ready;
        !local_io_ack_n |-> cpu_ready;
    endproperty
    a_ack_ready: assert property (p_ack_ready)
        else $error("ready not driven with local io ack");

    property p_periph_map;
        !parallel_port_sel_n |-> !local_io_ack_n
            && $past(st.addr[`BAD_SEL_MSB:`BAD_SEL_LSB]) == `BAD_SEL_PAR;
    endproperty
    a_periph_map: assert property (p_periph_map)
        else $error("parallel port select on wrong address");

    property p_tmr_map;
        !timer_sel_n |-> !local_io_ack_n
            && $past(st.addr[`BAD_SEL_MSB:`BAD_SEL_LSB]) == `BAD_SEL_TMR;
    endproperty
    a_tmr_map: assert property (p_tmr_map)
        else $error("timer select on wrong address");

    property p_irq_map;
        !irq_ctrl_sel_n |-> !local_io_ack_n
            && $past(st.addr[`BAD_SEL_MSB:`BAD_SEL_LSB]) == `BAD_SEL_IRQ;
    endproperty
    a_irq_map: assert property (p_irq_map)
        else $error("interrupt select on wrong address");

    property p_ser_map;
        !serial_sel_n |-> !local_io_ack_n
            && $past(st.addr[`BAD_SEL_MSB:`BAD_SEL_LSB]) == `BAD_SEL_SER;
    endproperty
    a_ser_map: assert property (p_ser_map)
        else $error("serial select on wrong address");

    property p_local_flags;
        !local_io_ack_n |-> !local_target_n && !local_buffer_en_n;
    endproperty
    a_local_flags: assert property (p_local_flags)
        else $error("local io without buffer enable or on-board flag");

    property p_dir;
        1'b1 |=> xfer_direction == !$past(dt_r);
    endproperty
    a_dir: assert property (p_dir)
        else $error("buffer direction not inverted status");

    property p_func;
        !local_io_ack_n |-> periph_func == $past(st.addr[`BAD_FUNC_MSB:`BAD_FUNC_LSB]);
    endproperty
    a_func: assert property (p_func)
        else $error("peripheral function bits wrong");

    property p_arb_offboard;
        arb_req |-> local_target_n && arb_status == $past(cpu_status);
    endproperty
    a_arb_offboard: assert property (p_arb_offboard)
        else $error("arbiter request on on-board cycle");

    property p_rom_ram_excl;
        !rom_ack_n |-> local_ram_req_n && $past(st.addr[`BAD_A19]);
    endproperty
    a_rom_ram_excl: assert property (p_rom_ram_excl)
        else $error("rom ack and ram request clash");

    property p_ram_map;
        !local_ram_req_n |-> rom_ack_n && !local_target_n && !$past(st.addr[`BAD_A19]);
    endproperty
    a_ram_map: assert property (p_ram_map)
        else $error("ram request outside low window");

    property p_pair_after_strobe;
        (rom_pair0_sel_n && rom_pair1_sel_n && rom_pair2_sel_n && rom_pair3_sel_n)
        || ($past(st.phase) == BAD_DATA && !rom_ack_n);
    endproperty
    a_pair_after_strobe: assert property (p_pair_after_strobe)
        else $error("rom pair select before strobe fell");

    property p_pair_addr;
        !rom_pair3_sel_n |-> rom_chip_addr == $past(st.addr[`BAD_CHIP_MSB:`BAD_CHIP_LSB]);
    endproperty
    a_pair_addr: assert property (p_pair_addr)
        else $error("rom chip address wrong");

    property p_onehot;
        $onehot0(~{irq_ctrl_sel_n, parallel_port_sel_n, timer_sel_n, serial_sel_n})
        && $onehot0(~{rom_pair0_sel_n, rom_pair1_sel_n, rom_pair2_sel_n, rom_pair3_sel_n});
    endproperty
    a_onehot: assert property (p_onehot)
        else $error("more than one select active");

    c_io_ack: cover property (!local_io_ack_n ##1 local_io_ack_n);
    c_rom_top: cover property (!rom_pair3_sel_n);
    c_rom_low: cover property (!rom_pair0_sel_n);
    c_ram_req: cover property (!local_ram_req_n);
    c_arb: cover property (arb_req);

endmodule

//--- bad_regs.svh
// constants for the board address decoder
`ifndef BAD_REGS_SVH
`define BAD_REGS_SVH

// ------------------------------------------------------------
// address fields
// ------------------------------------------------------------
`define BAD_ADDR_W       20
`define BAD_A19          19
`define BAD_IO_S2        2
`define BAD_IO_MASK      16'hffe0
`define BAD_IO_MATCH     16'h00c0
`define BAD_SEL_MSB      4
`define BAD_SEL_LSB      3
`define BAD_FUNC_MSB     2
`define BAD_FUNC_LSB     1
`define BAD_CHIP_MSB     12
`define BAD_CHIP_LSB     1
`define BAD_WIN_MSB      18
`define BAD_WIN_LSB      11

// ------------------------------------------------------------
// peripheral codes on address bits 4:3
// ------------------------------------------------------------
`define BAD_SEL_IRQ      2'h0
`define BAD_SEL_PAR      2'h1
`define BAD_SEL_TMR      2'h2
`define BAD_SEL_SER      2'h3

// ------------------------------------------------------------
// rom window masks on address bits 18:11
// ------------------------------------------------------------
`define BAD_WIN_MASK_4K  8'hfe
`define BAD_WIN_MASK_8K  8'hfc
`define BAD_WIN_MASK_16K 8'hf8
`define BAD_WIN_MASK_EXP 8'hf0
`define BAD_SEL_BIT_4K   0
`define BAD_SEL_BIT_8K   1
`define BAD_SEL_BIT_16K  2
`define BAD_SEL_EXP_MSB  3
`define BAD_SEL_EXP_LSB  2

// ------------------------------------------------------------
// misc values
// ------------------------------------------------------------
`define BAD_SW_OFF       2'h0
`define BAD_STAT_PASSIVE 3'h7
`define BAD_SEL_NONE     4'hf

`endif

//--- bad_pkg.sv
// types shared by the board address decoder
package bad_pkg;

    typedef enum logic [1:0] {
        BAD_IDLE = 2'b00,
        BAD_ADDR = 2'b01,
        BAD_DATA = 2'b10
    } bad_phase_type;

    typedef enum logic [1:0] {
        BAD_SZ_4K  = 2'b00,
        BAD_SZ_8K  = 2'b01,
        BAD_SZ_16K = 2'b10
    } bad_size_type;

    typedef struct packed {
        bad_phase_type phase;
        logic          io_flag;
        logic [19:0]   addr;
        logic          ack_n;
        logic          ready;
        logic [3:0]    periph_sel_n;
        logic          buf_en_n;
        logic          target_n;
        logic          dir;
        logic [1:0]    func;
        logic          prd_n;
        logic          pwr_n;
        logic          rom_ack_n;
        logic          ram_req_n;
        logic [3:0]    pair_sel_n;
        logic [11:0]   chip_addr;
        logic [2:0]    arb_status;
        logic          arb_req;
    } bad_state_type;

endpackage

//--- bad_win_decode.sv
// rom window lookup: range and pair select code from address bits 18:11
`timescale 1ns/100ps
`include "bad_regs.svh"

module bad_win_decode
    import bad_pkg::*;
(
    input  wire logic [7:0] win_bits,
    input  wire logic [1:0] chip_size,
    input  wire logic       expanded,
    output logic            range_out_a,
    output logic            range_out_b,
    output logic            sel_out_low,
    output logic            sel_out_high
);

    logic [7:0] mask;
    logic       hit;

    // ------------------------------------------------------------
    // window and select code
    // ------------------------------------------------------------
    always_comb begin
        mask         = `BAD_WIN_MASK_4K;
        sel_out_high = 1'b1;
        sel_out_low  = win_bits[`BAD_SEL_BIT_4K];
        if (expanded) begin
            // eight sockets: code walks 00..11 over the four 8k blocks
            mask         = `BAD_WIN_MASK_EXP;
            sel_out_high = win_bits[`BAD_SEL_EXP_MSB];
            sel_out_low  = win_bits[`BAD_SEL_EXP_LSB];
        end else begin
            unique case (bad_size_type'(chip_size))
                BAD_SZ_4K: begin
                    mask        = `BAD_WIN_MASK_4K;
                    sel_out_low = win_bits[`BAD_SEL_BIT_4K];
                end
                BAD_SZ_8K: begin
                    mask        = `BAD_WIN_MASK_8K;
                    sel_out_low = win_bits[`BAD_SEL_BIT_8K];
                end
                BAD_SZ_16K: begin
                    mask        = `BAD_WIN_MASK_16K;
                    sel_out_low = win_bits[`BAD_SEL_BIT_16K];
                end
                default: begin
                    // unused strap code: treat as smallest window
                    mask        = `BAD_WIN_MASK_4K;
                    sel_out_low = win_bits[`BAD_SEL_BIT_4K];
                end
            endcase
        end
        hit         = (win_bits & mask) == mask;
        range_out_a = ~hit;
        range_out_b = ~hit;
    end

endmodule

//--- bad_cpu_model.sv
// processor local bus model: address, status, io strobes and cycle end
`timescale 1ns/100ps

module bad_cpu_model (
    input  wire logic        core_clk,
    output logic [19:0]      addr,
    output logic [2:0]       cpu_status,
    output logic             ale,
    output logic             dt_r,
    output logic             io_read_cmd_n,
    output logic             io_write_cmd_n,
    output logic             cycle_done
);
    // ----------------------------------------------------------
    // idle levels
    // ----------------------------------------------------------
    initial begin
        addr           = 20'h5a5a5;
        cpu_status     = 3'h7;
        ale            = 1'b0;
        dt_r           = 1'b0;
        io_read_cmd_n  = 1'b1;
        io_write_cmd_n = 1'b1;
        cycle_done     = 1'b0;
    end

    // ----------------------------------------------------------
    // address phase, then io strobe for the data phase
    // ----------------------------------------------------------
    task automatic start(input logic [19:0] a, input logic [2:0] st, input logic wr);
        @(negedge core_clk);
        addr       = a;
        cpu_status = st;
        dt_r       = wr;
        ale        = 1'b1;
        @(negedge core_clk);
        ale = 1'b0;
        if (!st[2]) begin
            io_read_cmd_n  = wr;
            io_write_cmd_n = !wr;
        end
    endtask

    // released lines flip so a stale address can never look like a match
    task automatic finish();
        @(negedge core_clk);
        cycle_done     = 1'b1;
        io_read_cmd_n  = 1'b1;
        io_write_cmd_n = 1'b1;
        @(negedge core_clk);
        cycle_done = 1'b0;
        addr       = ~addr;
        cpu_status = 3'h7;
        dt_r       = ~dt_r;
    endtask
endmodule

//--- bad_top_bench.sv
// self-checking bench for the board address decoder
`timescale 1ns/100ps

module bad_top_bench;
    logic        core_clk;
    logic        rst;
    logic [1:0]  chip_size;
    logic        rom_expanded;
    logic [1:0]  config_switch;
    logic [19:0] addr;
    logic [2:0]  cpu_status;
    logic        ale, dt_r, io_read_cmd_n, io_write_cmd_n, cycle_done;
    logic        io_cycle_flag, local_io_ack_n, cpu_ready, local_buffer_en_n, local_target_n;
    logic        irq_ctrl_sel_n, parallel_port_sel_n, timer_sel_n, serial_sel_n;
    logic        xfer_direction, periph_rd_n, periph_wr_n, rom_ack_n, local_ram_req_n;
    logic        rom_pair0_sel_n, rom_pair1_sel_n, rom_pair2_sel_n, rom_pair3_sel_n, arb_req;
    logic [1:0]  periph_func;
    logic [11:0] rom_chip_addr;
    logic [2:0]  arb_status;
    logic [3:0]  psel_n;
    logic [3:0]  rsel_n;
    int          n_errors = 0;
    int          n_tests = 0;

    assign psel_n = {serial_sel_n, timer_sel_n, parallel_port_sel_n, irq_ctrl_sel_n};
    assign rsel_n = {rom_pair3_sel_n, rom_pair2_sel_n, rom_pair1_sel_n, rom_pair0_sel_n};

    bad_top dut (
        .core_clk, .rst, .addr, .cpu_status, .ale, .dt_r, .io_read_cmd_n, .io_write_cmd_n,
        .cycle_done, .chip_size, .rom_expanded, .config_switch, .io_cycle_flag,
        .local_io_ack_n, .cpu_ready, .irq_ctrl_sel_n, .parallel_port_sel_n, .timer_sel_n,
        .serial_sel_n, .local_buffer_en_n, .local_target_n, .xfer_direction, .periph_func,
        .periph_rd_n, .periph_wr_n, .rom_ack_n, .local_ram_req_n, .rom_pair0_sel_n,
        .rom_pair1_sel_n, .rom_pair2_sel_n, .rom_pair3_sel_n, .rom_chip_addr, .arb_status,
        .arb_req
    );

    bad_cpu_model u_cpu (
        .core_clk, .addr, .cpu_status, .ale, .dt_r, .io_read_cmd_n, .io_write_cmd_n,
        .cycle_done
    );

    // ----------------------------------------------------------
    // clock, compare and close
    // ----------------------------------------------------------
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    task automatic check(input logic [23:0] seen, input logic [23:0] exp, input string what);
        n_tests++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    task automatic end_sim();
        $display("tests %0d errors %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic check_idle(input string what);
        check({psel_n, rsel_n, local_io_ack_n, rom_ack_n, local_ram_req_n}, 24'h7ff, what);
        check({local_buffer_en_n, local_target_n, cpu_ready, arb_req}, 24'hc, what);
    endtask

    // ----------------------------------------------------------
    // one io cycle and one memory cycle, judged phase by phase
    // ----------------------------------------------------------
    task automatic io_case(input logic [19:0] a, input logic [2:0] st, input logic wr,
                           input logic hit);
        logic [3:0] exp_sel;
        exp_sel = hit ? ~(4'h1 << a[4:3]) : 4'hf;
        u_cpu.start(a, st, wr);
        @(negedge core_clk);
        check(io_cycle_flag, 1'b1, "io flag");
        @(negedge core_clk);
        check({local_io_ack_n, cpu_ready}, {!hit, hit}, "io ack");
        check(psel_n, exp_sel, "periph select");
        check({local_buffer_en_n, local_target_n}, {!hit, !hit}, "local flag");
        check(xfer_direction, !wr, "direction");
        check(periph_func, hit ? a[2:1] : 2'h0, "function");
        @(negedge core_clk);
        check({periph_rd_n, periph_wr_n}, hit ? {wr, !wr} : 2'h3, "strobe");
        check(arb_req, !hit, "arbiter request");
        if (!hit) check(arb_status, st, "arbiter status");
        u_cpu.finish();
        repeat (2) @(negedge core_clk);
        check_idle("io end");
    endtask

    task automatic mem_case(input logic [19:0] a, input logic [1:0] sz, input logic hit,
                            input logic [1:0] p);
        logic       rom;
        logic [3:0] exp_pair;
        rom       = hit & a[19];
        exp_pair  = rom ? ~(4'h1 << p) : 4'hf;
        chip_size = sz;
        u_cpu.start(a, 3'h5, 1'b0);
        @(negedge core_clk);
        check(io_cycle_flag, 1'b0, "memory flag");
        @(negedge core_clk);
        check({local_io_ack_n, local_target_n}, {1'b1, !hit}, "window hit");
        check({rom_ack_n, local_ram_req_n}, {!rom, !(hit & !a[19])}, "rom or ram");
        check(local_buffer_en_n, !rom, "buffer");
        check(rom_chip_addr, rom ? a[12:1] : 12'h0, "chip address");
        @(negedge core_clk);
        check(rsel_n, exp_pair, "pair select");
        u_cpu.finish();
        repeat (2) @(negedge core_clk);
        check_idle("memory end");
    endtask

    // ----------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------
    task automatic test_reset();
        check(arb_status, 3'h7, "reset status");
        check({io_cycle_flag, periph_func, rom_chip_addr}, 24'h0, "reset");
        check(xfer_direction, !dt_r, "idle direction");
        check_idle("reset");
        u_cpu.start(20'h000c2, 3'h1, 1'b0);
        @(negedge core_clk);
        rst = 1'b1;
        @(negedge core_clk);
        check_idle("mid reset");
        check(xfer_direction, 1'b0, "reset direction");
        rst = 1'b0;
        u_cpu.finish();
        check_idle("after reset");
    endtask

    task automatic test_io_local();
        io_case(20'h000c2, 3'h1, 1'b0, 1'b1);
        io_case(20'h000ca, 3'h2, 1'b1, 1'b1);
        io_case(20'h000d4, 3'h1, 1'b0, 1'b1);
        io_case(20'h000de, 3'h2, 1'b1, 1'b1);
        io_case(20'h000c0, 3'h2, 1'b1, 1'b1);
    endtask

    task automatic test_io_miss();
        io_case(20'h001c2, 3'h1, 1'b0, 1'b0);
        io_case(20'h00082, 3'h2, 1'b1, 1'b0);
        io_case(20'h000e2, 3'h1, 1'b0, 1'b0);
        io_case(20'h080c2, 3'h2, 1'b1, 1'b0);
    endtask

    // switches are left on in base mode; only the expanded decode reads them
    task automatic test_rom_base();
        mem_case(20'hff000, 2'h0, 1'b1, 2'h2);
        mem_case(20'hff7fe, 2'h0, 1'b1, 2'h2);
        mem_case(20'hff800, 2'h0, 1'b1, 2'h3);
        mem_case(20'hfeffe, 2'h0, 1'b0, 2'h0);
        mem_case(20'hfe000, 2'h1, 1'b1, 2'h2);
        mem_case(20'hff000, 2'h1, 1'b1, 2'h3);
        mem_case(20'hfdffe, 2'h1, 1'b0, 2'h0);
        mem_case(20'hfc000, 2'h2, 1'b1, 2'h2);
        mem_case(20'hfe000, 2'h2, 1'b1, 2'h3);
        mem_case(20'hfbffe, 2'h2, 1'b0, 2'h0);
        mem_case(20'hff800, 2'h3, 1'b1, 2'h3);
        mem_case(20'hfe000, 2'h3, 1'b0, 2'h0);
        mem_case(20'h7f000, 2'h0, 1'b1, 2'h0);
        mem_case(20'h000c2, 2'h0, 1'b0, 2'h0);
    endtask

    task automatic test_rom_expanded();
        rom_expanded  = 1'b1;
        config_switch = 2'h0;
        mem_case(20'hf8000, 2'h0, 1'b1, 2'h0);
        mem_case(20'hf9ffe, 2'h0, 1'b1, 2'h0);
        mem_case(20'hfa000, 2'h0, 1'b1, 2'h1);
        mem_case(20'hfbffe, 2'h0, 1'b1, 2'h1);
        mem_case(20'hfc000, 2'h0, 1'b1, 2'h2);
        mem_case(20'hfffff, 2'h0, 1'b1, 2'h3);
        mem_case(20'hf7ffe, 2'h0, 1'b0, 2'h0);
        mem_case(20'h78000, 2'h0, 1'b1, 2'h0);
        config_switch = 2'h1;
        mem_case(20'hf8000, 2'h0, 1'b0, 2'h0);
    endtask

    // ----------------------------------------------------------
    // main sequence and hang guard
    // ----------------------------------------------------------
    initial begin
        rst           = 1'b1;
        chip_size     = 2'h0;
        rom_expanded  = 1'b0;
        config_switch = 2'h3;
        repeat (16) @(negedge core_clk);
        rst = 1'b0;
        @(negedge core_clk);
        test_reset();
        test_io_local();
        test_io_miss();
        test_rom_base();
        test_rom_expanded();
        end_sim();
    end

    initial begin
        repeat (5000) @(posedge core_clk);
        n_errors++;
        end_sim();
    end
endmodule
